//--- shift_normalize_unit_regs.vh
`ifndef SHIFT_NORMALIZE_UNIT_REGS_VH
`define SHIFT_NORMALIZE_UNIT_REGS_VH

// ==========================================================================
// Word layout
// ==========================================================================
`define SNU_WORD_W         60
`define SNU_SIGN_BIT       59
`define SNU_EXP_MSB        58
`define SNU_EXP_LSB        48
`define SNU_COEF_MSB       47
`define SNU_COEF_W         48
`define SNU_EXP_W          11
`define SNU_POS_ZERO       60'h000_0000_0000_0000

// ==========================================================================
// Shift count register layout
// ==========================================================================
`define SNU_CNT_W          18
`define SNU_CNT_SIGN       17
`define SNU_CNT_RANGE_MSB  10
`define SNU_CNT_RANGE_LSB  6
`define SNU_AMT_MSB        5
`define SNU_AMT_W          6
`define SNU_RANGE_ONES     5'h1f
`define SNU_CNT_ZERO       18'h0_0000
`define SNU_CNT_NORM_ZERO  18'h0_0030

// ==========================================================================
// Exponent patterns, sign-corrected, and bias
// ==========================================================================
`define SNU_EXP_INF        11'h7ff
`define SNU_EXP_INDEF      11'h3ff
`define SNU_EXP_UFLOW      11'h000
`define SNU_EXP_BIAS       13'h0400
`define SNU_EXP_BIAS_M1    13'h03ff
`define SNU_XW             13

// ==========================================================================
// Operations
// ==========================================================================
`define SNU_OP_W           2
`define SNU_OP_FIX_LEFT    2'h0
`define SNU_OP_FIX_RIGHT   2'h1
`define SNU_OP_VAR_SHIFT   2'h2
`define SNU_OP_NORMALIZE   2'h3

// ==========================================================================
// Misc
// ==========================================================================
`define SNU_ROT_WRAP       6'h3c
`define SNU_LEAD_W         6

`endif

//--- snu_word_shifter.v
`timescale 1ns/100ps
`default_nettype none
`include "shift_normalize_unit_regs.vh"

// ==========================================================================
// Left circular or sign-extending right shift of one word
// ==========================================================================
module snu_word_shifter (
   input  wire [`SNU_WORD_W-1:0] i_data,
   input  wire [`SNU_AMT_W-1:0]  i_amount,
   input  wire                   i_right,
   output wire [`SNU_WORD_W-1:0] o_data
);

   wire [`SNU_AMT_W-1:0]    rot_amt;
   wire [2*`SNU_WORD_W-1:0] rot_dbl;
   wire signed [`SNU_WORD_W-1:0] sdata;
   wire [`SNU_WORD_W-1:0]   right_word;

   // Counts of 60..63 wrap, a full turn leaves the word unchanged
   assign rot_amt = (i_amount >= `SNU_ROT_WRAP) ?
                    (i_amount - `SNU_ROT_WRAP) : i_amount;
   // Top bits re-enter at the bottom in order
   assign rot_dbl = {i_data, i_data} << rot_amt;
   // Low bits drop off, sign copies fill the top
   assign sdata      = i_data;
   assign right_word = sdata >>> i_amount;
   assign o_data = i_right ? right_word
                           : rot_dbl[2*`SNU_WORD_W-1:`SNU_WORD_W];

endmodule // snu_word_shifter
`default_nettype wire

//--- snu_lead_count.v
`timescale 1ns/100ps
`default_nettype none
`include "shift_normalize_unit_regs.vh"

// ==========================================================================
// Leading zero count of a sign-corrected coefficient
// ==========================================================================
module snu_lead_count (
   input  wire [`SNU_COEF_W-1:0] i_coef,
   output wire [`SNU_LEAD_W-1:0] o_count,
   output wire                   o_zero
);

   wire [`SNU_LEAD_W-1:0] cnt_chain [0:`SNU_COEF_W];

   assign cnt_chain[0] = `SNU_LEAD_W'h00;

   // Scan from the bottom; the highest set bit writes last
   genvar gi;
   generate
      for (gi = 0; gi < `SNU_COEF_W; gi = gi + 1) begin : g_scan
         // Distance up to the coefficient top, cut to the count width
         localparam [`SNU_LEAD_W-1:0] DIST = `SNU_COEF_MSB - gi;
         assign cnt_chain[gi+1] = i_coef[gi] ? DIST : cnt_chain[gi];
      end
   endgenerate

   assign o_count = cnt_chain[`SNU_COEF_W];
   assign o_zero  = ~|i_coef;

endmodule // snu_lead_count
`default_nettype wire

//--- shift_normalize_unit.v
`timescale 1ns/100ps
`default_nettype none
`include "shift_normalize_unit_regs.vh"

module shift_normalize_unit (
   input  wire                    i_core_clk,
   input  wire                    i_rst_n,
   input  wire                    i_op_valid,
   input  wire [`SNU_OP_W-1:0]    i_opcode,
   input  wire [`SNU_WORD_W-1:0]  i_destination_operand_reg,
   input  wire [`SNU_WORD_W-1:0]  i_source_operand_reg,
   input  wire [`SNU_CNT_W-1:0]   i_shift_count_reg,
   input  wire [`SNU_AMT_W-1:0]   i_immediate_shift_field,
   output wire                    o_ready,
   output reg                     o_done,
   output reg  [`SNU_WORD_W-1:0]  o_result,
   output reg                     o_count_we,
   output reg  [`SNU_CNT_W-1:0]   o_count,
   output reg                     o_infinite_exit,
   output reg                     o_indefinite_exit
);

   // =======================================================================
   // State machine
   // =======================================================================
   // One-hot: bit 0 idle and ready, bit 1 executing
   localparam [1:0] ST_IDLE = 2'h1;
   localparam [1:0] ST_EXEC = 2'h2;

   reg  [1:0]              state_ff;
   reg  [1:0]              nxt_state;
   reg  [`SNU_OP_W-1:0]    op_ff;
   reg  [`SNU_WORD_W-1:0]  dest_ff;
   reg  [`SNU_WORD_W-1:0]  src_ff;
   reg  [`SNU_CNT_W-1:0]   cnt_ff;
   reg  [`SNU_AMT_W-1:0]   imm_ff;

   wire                    take;

   assign o_ready = state_ff[0];
   assign take    = i_op_valid & o_ready;

   // One cycle of work after every take; no request is queued
   always @* begin
      case (state_ff)
         ST_IDLE: begin
            nxt_state = take ? ST_EXEC : ST_IDLE;
         end
         ST_EXEC: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            // An illegal code falls back to idle rather than locking up
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Operands are held so the caller may change them after the take
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         op_ff    <= `SNU_OP_FIX_LEFT;
         dest_ff  <= `SNU_POS_ZERO;
         src_ff   <= `SNU_POS_ZERO;
         cnt_ff   <= `SNU_CNT_ZERO;
         imm_ff   <= `SNU_AMT_W'h00;
      end else if (take) begin
         op_ff    <= i_opcode;
         dest_ff  <= i_destination_operand_reg;
         src_ff   <= i_source_operand_reg;
         cnt_ff   <= i_shift_count_reg;
         imm_ff   <= i_immediate_shift_field;
      end
   end

   // =======================================================================
   // Shift path
   // =======================================================================
   wire                    is_var;
   wire                    is_fix_right;
   wire                    cnt_neg;
   wire [4:0]              cnt_range;
   wire                    cnt_too_far;
   wire [`SNU_AMT_W-1:0]   cnt_low;
   wire [`SNU_AMT_W-1:0]   var_amount;
   wire [`SNU_AMT_W-1:0]   sh_amount;
   wire                    sh_right;
   wire [`SNU_WORD_W-1:0]  sh_in;
   wire [`SNU_WORD_W-1:0]  sh_out;
   wire [`SNU_WORD_W-1:0]  var_result;

   assign is_var       = (op_ff == `SNU_OP_VAR_SHIFT);
   assign is_fix_right = (op_ff == `SNU_OP_FIX_RIGHT);

   // Only bit 17, bits 6-10 and bits 0-5 are looked at
   assign cnt_neg   = cnt_ff[`SNU_CNT_SIGN];
   assign cnt_range = cnt_ff[`SNU_CNT_RANGE_MSB:`SNU_CNT_RANGE_LSB];
   assign cnt_low   = cnt_ff[`SNU_AMT_MSB:0];
   // Negative counts are ones' complement, so invert for the distance
   assign var_amount = cnt_neg ? ~cnt_low : cnt_low;
   // Past 63 places right nothing of the word survives
   assign cnt_too_far = cnt_neg & (cnt_range != `SNU_RANGE_ONES);

   // Fixed shifts work on the destination, the variable one on the source
   assign sh_amount = is_var ? var_amount : imm_ff;
   assign sh_right  = is_var ? cnt_neg : is_fix_right;
   assign sh_in     = is_var ? src_ff : dest_ff;

   // Positive zero, not a word of sign bits, for an overlong right shift
   assign var_result = cnt_too_far ? `SNU_POS_ZERO : sh_out;

   snu_word_shifter u_shifter (
      .i_data   (sh_in),
      .i_amount (sh_amount),
      .i_right  (sh_right),
      .o_data   (sh_out)
   );

   // =======================================================================
   // Normalize path
   // =======================================================================
   wire                    n_sign;
   wire [`SNU_WORD_W-1:0]  n_mag;
   wire [`SNU_EXP_W-1:0]   n_exp;
   wire [`SNU_COEF_W-1:0]  n_coef;
   wire [`SNU_LEAD_W-1:0]  n_lead;
   wire                    n_coef_zero;
   wire                    n_inf;
   wire                    n_indef;
   wire                    n_uflow;
   wire [`SNU_XW-1:0]      exp_wide;
   wire [`SNU_XW-1:0]      exp_true;
   wire [`SNU_XW-1:0]      exp_adj;
   wire [`SNU_XW-1:0]      exp_enc;
   wire [`SNU_EXP_W-1:0]   exp_out;
   wire [`SNU_EXP_W-1:0]   exp_field;
   wire                    exp_pos_in;
   wire                    exp_neg_out;
   wire [2*`SNU_COEF_W-1:0] coef_dbl;
   wire [`SNU_WORD_W-1:0]  norm_word;

   // Negative words are ones' complements; work on the magnitude
   assign n_sign = src_ff[`SNU_SIGN_BIT];
   assign n_mag  = n_sign ? ~src_ff : src_ff;
   assign n_exp  = n_mag[`SNU_EXP_MSB:`SNU_EXP_LSB];
   assign n_coef = n_mag[`SNU_COEF_MSB:0];

   assign n_inf   = (n_exp == `SNU_EXP_INF);
   assign n_indef = (n_exp == `SNU_EXP_INDEF);
   assign n_uflow = (n_exp == `SNU_EXP_UFLOW);

   snu_lead_count u_lead (
      .i_coef  (n_coef),
      .o_count (n_lead),
      .o_zero  (n_coef_zero)
   );

   // Biased exponent to signed value, less the shift, and back.
   // Top field bit set: non-negative exponent with the full bias;
   // clear: negative exponent held in ones' complement form.
   assign exp_pos_in  = n_exp[`SNU_EXP_W-1];
   assign exp_wide    = {2'b00, n_exp};
   assign exp_true    = exp_pos_in ? (exp_wide - `SNU_EXP_BIAS)
                                   : (exp_wide - `SNU_EXP_BIAS_M1);
   assign exp_adj     = exp_true - {7'h00, n_lead};
   assign exp_neg_out = exp_adj[`SNU_XW-1];
   assign exp_enc     = exp_neg_out ? (exp_adj + `SNU_EXP_BIAS_M1)
                                    : (exp_adj + `SNU_EXP_BIAS);
   // Limitation: an exponent driven below range by the shift wraps,
   // and no underflow condition is raised for it
   assign exp_out  = exp_enc[`SNU_EXP_W-1:0];

   // Sign copies enter from below so negative values stay consistent
   assign coef_dbl = {src_ff[`SNU_COEF_MSB:0], {`SNU_COEF_W{n_sign}}}
                     << n_lead;
   // The exponent is complemented with the rest of a negative word
   assign exp_field = n_sign ? ~exp_out : exp_out;
   assign norm_word = {n_sign, exp_field,
                       coef_dbl[2*`SNU_COEF_W-1:`SNU_COEF_W]};

   // =======================================================================
   // Normalize operand classes, highest priority first
   // =======================================================================
   wire                    n_special;
   wire                    n_zero_uflow;
   wire                    n_zero_plain;

   // Specials win, so an infinite word with a zero coefficient stays put
   assign n_special    = n_inf | n_indef;
   assign n_zero_uflow = ~n_special & n_coef_zero & n_uflow;
   assign n_zero_plain = ~n_special & n_coef_zero & ~n_uflow;
   // Anything else is a regular operand and takes the normalize path

   // =======================================================================
   // Result selection
   // =======================================================================
   reg  [`SNU_WORD_W-1:0]  nxt_result;
   reg                     nxt_count_we;
   reg  [`SNU_CNT_W-1:0]   nxt_count;
   reg                     nxt_inf_exit;
   reg                     nxt_indef_exit;

   always @* begin
      // Shift answer by default; only normalize writes the count
      nxt_result     = sh_out;
      nxt_count_we   = 1'b0;
      nxt_count      = `SNU_CNT_ZERO;
      nxt_inf_exit   = 1'b0;
      nxt_indef_exit = 1'b0;
      case (op_ff)
         `SNU_OP_FIX_LEFT,
         `SNU_OP_FIX_RIGHT: begin
            nxt_result = sh_out;
         end
         `SNU_OP_VAR_SHIFT: begin
            nxt_result = var_result;
         end
         `SNU_OP_NORMALIZE: begin
            // Every normalize answer rewrites the count register
            nxt_count_we = 1'b1;
            if (n_special) begin
               // Special operands pass through untouched
               nxt_result     = src_ff;
               nxt_count      = `SNU_CNT_ZERO;
               nxt_inf_exit   = n_inf;
               nxt_indef_exit = n_indef;
            end else if (n_zero_uflow) begin
               nxt_result = `SNU_POS_ZERO;
               nxt_count  = `SNU_CNT_ZERO;
            end else if (n_zero_plain) begin
               nxt_result = `SNU_POS_ZERO;
               nxt_count  = `SNU_CNT_NORM_ZERO;
            end else begin
               nxt_result = norm_word;
               nxt_count  = {12'h000, n_lead};
            end
         end
         default: begin
            nxt_result = sh_out;
         end
      endcase
   end

   // =======================================================================
   // Registered answer, presented with o_done and held until the next one
   // =======================================================================
   wire exec;

   assign exec = state_ff[1];

   // Strobes are rebuilt every cycle, so none can stick high
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_done            <= 1'b0;
         o_count_we        <= 1'b0;
         o_infinite_exit   <= 1'b0;
         o_indefinite_exit <= 1'b0;
      end else begin
         o_done            <= exec;
         o_count_we        <= exec & nxt_count_we;
         o_infinite_exit   <= exec & nxt_inf_exit;
         o_indefinite_exit <= exec & nxt_indef_exit;
      end
   end

   // Data holds its value between answers so the caller may read late
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_result <= `SNU_POS_ZERO;
         o_count  <= `SNU_CNT_ZERO;
      end else if (exec) begin
         o_result <= nxt_result;
         o_count  <= nxt_count;
      end
   end

endmodule // shift_normalize_unit
`default_nettype wire

//--- shift_normalize_unit_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "shift_normalize_unit_regs.vh"
module shift_normalize_unit_properties (
   input wire logic        i_core_clk,
   input wire logic        i_rst_n,
   input wire logic        i_op_valid,
   input wire logic [1:0]  i_opcode,
   input wire logic [59:0] i_destination_operand_reg,
   input wire logic [59:0] i_source_operand_reg,
   input wire logic [17:0] i_shift_count_reg,
   input wire logic [5:0]  i_immediate_shift_field,
   input wire logic        o_ready,
   input wire logic        o_done,
   input wire logic [59:0] o_result,
   input wire logic        o_count_we,
   input wire logic [17:0] o_count,
   input wire logic        o_infinite_exit,
   input wire logic        o_indefinite_exit
);
   // ======================================================================
   // Helpers
   // ======================================================================
   wire logic        take = i_op_valid && o_ready;
   wire logic        norm = take && (i_opcode == `SNU_OP_NORMALIZE);
   // Exponent seen as if the operand were positive
   wire logic [10:0] sexp = i_source_operand_reg[59] ?
                            ~i_source_operand_reg[58:48] :
                            i_source_operand_reg[58:48];
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // ======================================================================
   // Properties
   // ======================================================================
   a_done_latency: assert property (
      take |=> !o_done ##1 o_done)
      else $error("answer not on second edge after take");
   a_ready_drop: assert property (
      take |=> !o_ready ##1 o_ready)
      else $error("ready wrong while busy");
   a_done_pulse: assert property (o_done |=> !o_done)
      else $error("done longer than one cycle");
   a_we_norm: assert property (
      take |=> ##1 (o_count_we ==
                    ($past(i_opcode, 2) == `SNU_OP_NORMALIZE)))
      else $error("count write strobe wrong");
   a_fixed_right: assert property (
      take && i_opcode == `SNU_OP_FIX_RIGHT |=> ##1
      $signed(o_result) ==
      ($signed($past(i_destination_operand_reg, 2)) >>>
       $past(i_immediate_shift_field, 2)))
      else $error("fixed right shift wrong");
   a_var_range: assert property (
      take && i_opcode == `SNU_OP_VAR_SHIFT && i_shift_count_reg[17] &&
      i_shift_count_reg[10:6] != 5'h1f |=> ##1 o_result == `SNU_POS_ZERO)
      else $error("out of range right shift not zero");
   a_inf_copy: assert property (
      norm && sexp == `SNU_EXP_INF |=> ##1 o_infinite_exit &&
      o_count == `SNU_CNT_ZERO && o_result == $past(i_source_operand_reg, 2))
      else $error("infinite operand handling wrong");
   a_indef_copy: assert property (
      norm && sexp == `SNU_EXP_INDEF |=> ##1 o_indefinite_exit &&
      o_count == `SNU_CNT_ZERO && o_result == $past(i_source_operand_reg, 2))
      else $error("indefinite operand handling wrong");
   a_rot_ones: assert property (
      take && i_opcode == `SNU_OP_FIX_LEFT |=> ##1 $countones(o_result) ==
      $countones($past(i_destination_operand_reg, 2)))
      else $error("rotation changed the ones count");
endmodule // shift_normalize_unit_properties
`default_nettype wire

//--- tb_shift_normalize_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "shift_normalize_unit_regs.vh"
module tb_shift_normalize_unit;
   // ======================================================================
   // Signals
   // ======================================================================
   logic        i_core_clk, i_rst_n, i_op_valid;
   logic [1:0]  i_opcode;
   logic [59:0] i_destination_operand_reg, i_source_operand_reg;
   logic [17:0] i_shift_count_reg;
   logic [5:0]  i_immediate_shift_field;
   wire         o_ready, o_done, o_count_we;
   wire         o_infinite_exit, o_indefinite_exit;
   wire  [59:0] o_result;
   wire  [17:0] o_count;
   int          n_fail, comparisons;
   localparam logic [59:0] W_A = 60'h4d3_b000_0000_0049;
   localparam logic [59:0] W_B = 60'hc01_2240_a48f_3005;
   shift_normalize_unit shift_normalize_unit_inst (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_op_valid(i_op_valid),
      .i_opcode(i_opcode),
      .i_destination_operand_reg(i_destination_operand_reg),
      .i_source_operand_reg(i_source_operand_reg),
      .i_shift_count_reg(i_shift_count_reg),
      .i_immediate_shift_field(i_immediate_shift_field),
      .o_ready(o_ready), .o_done(o_done), .o_result(o_result),
      .o_count_we(o_count_we), .o_count(o_count),
      .o_infinite_exit(o_infinite_exit),
      .o_indefinite_exit(o_indefinite_exit));
   always #5 i_core_clk = ~i_core_clk;
   // ======================================================================
   // Reference shifts and compares
   // ======================================================================
   function automatic logic [59:0] rol(input logic [59:0] d,
                                      input logic [5:0] n);
      logic [119:0] t;
      t = {d, d} << (n % 60);
      return t[119:60];
   endfunction
   function automatic logic [59:0] asr(input logic [59:0] d,
                                      input logic [5:0] n);
      return $signed(d) >>> n;
   endfunction
   task automatic cmp_word(input logic [59:0] got, input logic [59:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_count(input logic [17:0] got, input logic [17:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_flag(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // One request, answer judged on the second edge; fl is {we, inf, ind}
   task automatic run(input logic [1:0] op, input logic [59:0] d, s,
                      input logic [17:0] c, input logic [5:0] imm,
                      input logic [59:0] er, input logic [17:0] ec,
                      input logic [2:0] fl);
      int k;
      i_opcode = op;
      i_destination_operand_reg = d;
      i_source_operand_reg = s;
      i_shift_count_reg = c;
      i_immediate_shift_field = imm;
      i_op_valid = 1'b1;
      k = 0;
      while (o_ready !== 1'b1 && k < 20) begin
         @(negedge i_core_clk);
         k++;
      end
      if (o_ready !== 1'b1) begin
         n_fail++;
         summarize();
      end
      @(negedge i_core_clk);
      i_op_valid = 1'b0;
      cmp_flag(o_done, 1'b0);
      @(negedge i_core_clk);
      cmp_flag(o_done, 1'b1);
      cmp_word(o_result, er);
      cmp_flag(o_count_we, fl[2]);
      cmp_flag(o_infinite_exit, fl[1]);
      cmp_flag(o_indefinite_exit, fl[0]);
      if (fl[2])
         cmp_count(o_count, ec);
   endtask
   // ======================================================================
   // Scenarios
   // ======================================================================
   task automatic t_reset;
      cmp_flag(o_ready, 1'b1);
      cmp_flag(o_done, 1'b0);
      cmp_flag(o_count_we, 1'b0);
      cmp_flag(o_infinite_exit, 1'b0);
      cmp_flag(o_indefinite_exit, 1'b0);
      cmp_word(o_result, 60'h000_0000_0000_0000);
      cmp_count(o_count, 18'h0_0000);
   endtask
   // Every immediate count, 60..63 included
   task automatic t_fixed;
      for (int i = 0; i < 64; i++) begin
         run(`SNU_OP_FIX_LEFT, W_A, W_B, 18'h0_0000, i[5:0],
             rol(W_A, i[5:0]), 18'h0_0000, 3'h0);
         run(`SNU_OP_FIX_RIGHT, i[0] ? W_A : W_B, W_A, 18'h0_0000, i[5:0],
             asr(i[0] ? W_A : W_B, i[5:0]), 18'h0_0000, 3'h0);
      end
   endtask
   // Junk in bits 16:11 must never matter
   task automatic t_var;
      for (int i = 0; i < 64; i++) begin
         run(`SNU_OP_VAR_SHIFT, W_A, W_B, {1'b0, 6'h15, 5'h0a, i[5:0]},
             6'h0, rol(W_B, i[5:0]), 18'h0_0000, 3'h0);
         run(`SNU_OP_VAR_SHIFT, W_A, W_B, {1'b1, 6'h2a, 5'h1f, ~i[5:0]},
             6'h0, asr(W_B, i[5:0]), 18'h0_0000, 3'h0);
         run(`SNU_OP_VAR_SHIFT, W_A, W_B,
             {1'b1, 6'h3f, 5'h1f & ~(5'h01 << (i % 5)), i[5:0]}, 6'h0,
             60'h000_0000_0000_0000, 18'h0_0000, 3'h0);
      end
   endtask
   task automatic t_norm;
      run(`SNU_OP_NORMALIZE, W_A, 60'h41c_027d_4000_04b2, 18'h0_0000, 6'h0,
          60'h416_9f50_0001_2c80, 18'h0_0006, 3'h4);
      run(`SNU_OP_NORMALIZE, W_A, ~60'h41c_027d_4000_04b2, 18'h0_0000, 6'h0,
          ~60'h416_9f50_0001_2c80, 18'h0_0006, 3'h4);
      run(`SNU_OP_NORMALIZE, W_A, 60'h440_0000_0000_0001, 18'h0_0000, 6'h0,
          60'h411_8000_0000_0000, 18'h0_002f, 3'h4);
      run(`SNU_OP_NORMALIZE, W_A, 60'h420_8000_0000_0001, 18'h0_0000, 6'h0,
          60'h420_8000_0000_0001, 18'h0_0000, 3'h4);
      run(`SNU_OP_NORMALIZE, W_A, 60'h400_0000_0000_0000, 18'h0_0000, 6'h0,
          60'h000_0000_0000_0000, 18'h0_0030, 3'h4);
      run(`SNU_OP_NORMALIZE, W_A, 60'hbff_ffff_ffff_ffff, 18'h0_0000, 6'h0,
          60'h000_0000_0000_0000, 18'h0_0030, 3'h4);
      run(`SNU_OP_NORMALIZE, W_A, 60'h000_0000_0000_0000, 18'h0_0001, 6'h0,
          60'h000_0000_0000_0000, 18'h0_0000, 3'h4);
      run(`SNU_OP_NORMALIZE, W_A, 60'hfff_ffff_ffff_ffff, 18'h0_0001, 6'h0,
          60'h000_0000_0000_0000, 18'h0_0000, 3'h4);
      run(`SNU_OP_NORMALIZE, W_A, 60'h7ff_0000_1234_5678, 18'h0_0000, 6'h0,
          60'h7ff_0000_1234_5678, 18'h0_0000, 3'h6);
      run(`SNU_OP_NORMALIZE, W_A, 60'h800_1234_0000_0001, 18'h0_0000, 6'h0,
          60'h800_1234_0000_0001, 18'h0_0000, 3'h6);
      run(`SNU_OP_NORMALIZE, W_A, 60'h3ff_0a00_0000_0003, 18'h0_0000, 6'h0,
          60'h3ff_0a00_0000_0003, 18'h0_0000, 3'h5);
      run(`SNU_OP_NORMALIZE, W_A, 60'hc00_0000_5000_0000, 18'h0_0000, 6'h0,
          60'hc00_0000_5000_0000, 18'h0_0000, 3'h5);
   endtask
   initial begin
      i_core_clk = 1'b0;
      i_rst_n = 1'b0;
      i_op_valid = 1'b0;
      i_opcode = 2'h0;
      i_destination_operand_reg = 60'h000_0000_0000_0000;
      i_source_operand_reg = 60'h000_0000_0000_0000;
      i_shift_count_reg = 18'h0_0000;
      i_immediate_shift_field = 6'h00;
      n_fail = 0;
      comparisons = 0;
      repeat (5) @(negedge i_core_clk);
      t_reset();
      i_rst_n = 1'b1;
      t_fixed();
      t_var();
      t_norm();
      summarize();
   end
endmodule // tb_shift_normalize_unit
bind shift_normalize_unit shift_normalize_unit_properties
   shift_normalize_unit_properties_inst (
   .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_op_valid(i_op_valid),
   .i_opcode(i_opcode),
   .i_destination_operand_reg(i_destination_operand_reg),
   .i_source_operand_reg(i_source_operand_reg),
   .i_shift_count_reg(i_shift_count_reg),
   .i_immediate_shift_field(i_immediate_shift_field),
   .o_ready(o_ready), .o_done(o_done), .o_result(o_result),
   .o_count_we(o_count_we), .o_count(o_count),
   .o_infinite_exit(o_infinite_exit), .o_indefinite_exit(o_indefinite_exit));
`default_nettype wire
